/* inc/pin_mux_regs.vh */
/*
  Constants for the reset-strapped parallel/host pin multiplexer.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH

// ----------------------------------------------------------------------
// Mode encoding
// ----------------------------------------------------------------------
`define MODE_PARALLEL_IO    1'b0
`define MODE_MEMORY_HOST    1'b1
`define MODE_RESET_VALUE    1'b0

// ----------------------------------------------------------------------
// Bus selection register layout (read-only view)
// ----------------------------------------------------------------------
`define BUS_SEL_WIDTH       16
`define BUS_SEL_MODE_BIT    0

// ----------------------------------------------------------------------
// Parallel I/O line layout
// ----------------------------------------------------------------------
`define PIO_LINES           46
`define PIO_ADDR_LSB        0
`define PIO_DATA_LSB        4
`define PIO_CTRL_LSB        20
`define PIO_HDATA_LSB       36
`define PIO_HCTRL0          44
`define PIO_HCTRL1          45

// ----------------------------------------------------------------------
// Control pin positions in memory interface mode
// ----------------------------------------------------------------------
`define CTRL_READ           0
`define CTRL_OUT_EN         1
`define CTRL_WRITE          2
`define CTRL_READY          3
`define CTRL_CE_LSB         4
`define CTRL_BE_LSB         8
`define CTRL_CKE            12
`define CTRL_SYNC_OUTPUT_ENABLE_THREE           13
`define CTRL_HOLD           14
`define CTRL_HOLD_ACKNOWLEDGE          15

`endif

/* src/parallel_host_pin_mux.v */
/*
  Reset-strapped pin multiplexer for the parallel port (address, data,
  control) and the host port (data, two controls).
  Assumes the memory interface, host port and parallel I/O block sit
  on clock_in, and that the strap pin is asynchronous.
*/
`timescale 1ns/1ps
`include "pin_mux_regs.vh"

// Overview of operation
// - Strap level sampled at reset release fixes the mode: low parallel I/O, high memory.
// - In parallel I/O mode low address and data pins are reserved and undriven.
// - Parallel I/O mode reads back as mode bit 0 in bus selection register.
// - Memory mode routes address 21..2 and data 31..0 one-to-one to pins.
// - Memory mode reads back as mode bit 1 in bus selection register.
// - Memory mode control pins carry strobes, ready, enables, clock enable, hold signals.
// - Parallel I/O mode: upper address, upper data, control pins map to lines 0..35.
// - Parallel I/O mode disables memory and host controllers from all pins.
// - Parallel I/O mode: host data to lines 43..36, host controls to 44, 45.
// - Memory mode: host data to host bus, controls to address strobe, byte identify.
// - Host address and data both travel over the eight host data pins.
// - Memory clock gated when unselected; disabled access errors when time-out enabled.
module parallel_host_pin_mux #(
  parameter ADDR_W = 20,
  parameter DATA_W = 32,
  parameter CTRL_W = 16,
  parameter HD_W   = 8
) (
  input  wire                     clock_in,
  input  wire                     reset_n_in,
  input  wire                     mux_mode_strap_pin_in,
  // Pads
  input  wire [ADDR_W-1:0]        addr_pin_in,
  output reg  [ADDR_W-1:0]        addr_pin_out,
  output reg  [ADDR_W-1:0]        addr_pin_oe_out,
  input  wire [DATA_W-1:0]        data_pin_in,
  output reg  [DATA_W-1:0]        data_pin_out,
  output reg  [DATA_W-1:0]        data_pin_oe_out,
  input  wire [CTRL_W-1:0]        ctrl_pin_in,
  output reg  [CTRL_W-1:0]        ctrl_pin_out,
  output reg  [CTRL_W-1:0]        ctrl_pin_oe_out,
  input  wire [HD_W-1:0]          host_data_pins_in,
  output reg  [HD_W-1:0]          host_data_pins_out,
  output reg  [HD_W-1:0]          host_data_pins_oe_out,
  input  wire                     host_control_pin_0_in,
  input  wire                     host_control_pin_1_in,
  // External memory interface side
  input  wire [ADDR_W-1:0]        mem_addr_in,
  input  wire [DATA_W-1:0]        mem_data_in,
  input  wire                     mem_data_oe_in,
  output reg  [DATA_W-1:0]        mem_data_out,
  input  wire                     mem_read_strobe_in,
  input  wire                     mem_output_strobe_in,
  input  wire                     mem_write_strobe_in,
  output reg                      memory_ready_input_out,
  input  wire [3:0]               mem_chip_enable_in,
  input  wire [3:0]               mem_byte_enable_in,
  input  wire                     sync_dram_clock_enable_in,
  input  wire                     sync_output_enable_three_in,
  input  wire                     mem_hold_request_in,
  output reg                      mem_hold_request_out,
  input  wire                     hold_acknowledge_in,
  output wire                     mem_clock_enable_out,
  // Host port interface side
  input  wire [HD_W-1:0]          host_data_in,
  input  wire                     host_data_oe_in,
  output reg  [HD_W-1:0]          host_data_out,
  output reg                      host_address_strobe_out,
  output reg                      host_byte_identify_out,
  output wire                     host_port_enable_out,
  // Parallel I/O block side
  input  wire [`PIO_LINES-1:0]    parallel_io_lines_data_in,
  input  wire [`PIO_LINES-1:0]    parallel_io_lines_dir_in,
  output reg  [`PIO_LINES-1:0]    parallel_io_lines_out,
  // Status and bus error
  input  wire                     peripheral_timeout_enable_in,
  input  wire                     disabled_access_in,
  output reg                      bus_error_out,
  output wire [`BUS_SEL_WIDTH-1:0] bus_selection_register_out
);

  localparam PIO_ADDR_W = 4;
  localparam PIO_DATA_W = 16;
  localparam ADDR_RSV_W = ADDR_W - PIO_ADDR_W;
  localparam DATA_RSV_W = DATA_W - PIO_DATA_W;

  wire strap_sync_level;
  reg  in_reset;
  reg  mode;
  reg  [ADDR_W-1:0] addr_s1;
  reg  [ADDR_W-1:0] addr_s2;
  reg  [DATA_W-1:0] data_s1;
  reg  [DATA_W-1:0] data_s2;
  reg  [CTRL_W-1:0] ctrl_s1;
  reg  [CTRL_W-1:0] ctrl_s2;
  reg  [HD_W+1:0]   host_s1;
  reg  [HD_W+1:0]   host_s2;

  // Free-running so the strap level is already valid while reset is held
  strap_sync u_strap_sync (
    .clock_in   (clock_in),
    .async_in   (mux_mode_strap_pin_in),
    .sync_out   (strap_sync_level)
  );

  // ----------------------------------------------------------------------
  // Mode capture: reset value during reset, loads strap at first cycle after
  // ----------------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      in_reset <= 1'b1;
      mode     <= `MODE_RESET_VALUE;
    end else begin
      in_reset <= 1'b0;
      if (in_reset) begin
        mode <= strap_sync_level;
      end
    end
  end

  assign bus_selection_register_out = {{(`BUS_SEL_WIDTH-1){1'b0}}, mode};
  assign mem_clock_enable_out       = (mode == `MODE_MEMORY_HOST);
  assign host_port_enable_out       = (mode == `MODE_MEMORY_HOST);

  // ----------------------------------------------------------------------
  // Pad input synchronisers
  // ----------------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      addr_s1 <= {ADDR_W{1'b0}};
      addr_s2 <= {ADDR_W{1'b0}};
      data_s1 <= {DATA_W{1'b0}};
      data_s2 <= {DATA_W{1'b0}};
      ctrl_s1 <= {CTRL_W{1'b0}};
      ctrl_s2 <= {CTRL_W{1'b0}};
      host_s1 <= {(HD_W+2){1'b0}};
      host_s2 <= {(HD_W+2){1'b0}};
    end else begin
      addr_s1 <= addr_pin_in;
      addr_s2 <= addr_s1;
      data_s1 <= data_pin_in;
      data_s2 <= data_s1;
      ctrl_s1 <= ctrl_pin_in;
      ctrl_s2 <= ctrl_s1;
      host_s1 <= {host_control_pin_1_in, host_control_pin_0_in, host_data_pins_in};
      host_s2 <= host_s1;
    end
  end

  // ----------------------------------------------------------------------
  // Registered routing
  // ----------------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      addr_pin_out            <= {ADDR_W{1'b0}};
      addr_pin_oe_out         <= {ADDR_W{1'b0}};
      data_pin_out            <= {DATA_W{1'b0}};
      data_pin_oe_out         <= {DATA_W{1'b0}};
      ctrl_pin_out            <= {CTRL_W{1'b0}};
      ctrl_pin_oe_out         <= {CTRL_W{1'b0}};
      host_data_pins_out      <= {HD_W{1'b0}};
      host_data_pins_oe_out   <= {HD_W{1'b0}};
      mem_data_out            <= {DATA_W{1'b0}};
      memory_ready_input_out  <= 1'b0;
      mem_hold_request_out    <= 1'b0;
      host_data_out           <= {HD_W{1'b0}};
      host_address_strobe_out <= 1'b0;
      host_byte_identify_out  <= 1'b0;
      parallel_io_lines_out   <= {`PIO_LINES{1'b0}};
      bus_error_out           <= 1'b0;
    end else if (mode == `MODE_MEMORY_HOST) begin
      addr_pin_out            <= mem_addr_in;
      addr_pin_oe_out         <= {ADDR_W{1'b1}};
      data_pin_out            <= mem_data_in;
      data_pin_oe_out         <= {DATA_W{mem_data_oe_in}};
      mem_data_out            <= data_s2;
      ctrl_pin_out            <= {hold_acknowledge_in, 1'b0, sync_output_enable_three_in,
                                  sync_dram_clock_enable_in, mem_byte_enable_in,
                                  mem_chip_enable_in, 1'b0, mem_write_strobe_in,
                                  mem_output_strobe_in, mem_read_strobe_in};
      ctrl_pin_oe_out         <= ~(({{(CTRL_W-1){1'b0}}, 1'b1} << `CTRL_READY) |
                                  ({{(CTRL_W-1){1'b0}}, 1'b1} << `CTRL_HOLD));
      memory_ready_input_out  <= ctrl_s2[`CTRL_READY];
      mem_hold_request_out    <= ctrl_s2[`CTRL_HOLD];
      host_data_pins_out      <= host_data_in;
      host_data_pins_oe_out   <= {HD_W{host_data_oe_in}};
      host_data_out           <= host_s2[HD_W-1:0];
      host_address_strobe_out <= host_s2[HD_W];
      host_byte_identify_out  <= host_s2[HD_W+1];
      parallel_io_lines_out   <= {`PIO_LINES{1'b0}};
      bus_error_out           <= 1'b0;
    end else begin
      // Controllers see idle inputs and never reach the pads
      mem_data_out            <= {DATA_W{1'b0}};
      memory_ready_input_out  <= 1'b0;
      mem_hold_request_out    <= 1'b0;
      host_data_out           <= {HD_W{1'b0}};
      host_address_strobe_out <= 1'b0;
      host_byte_identify_out  <= 1'b0;
      addr_pin_out            <= {parallel_io_lines_data_in[`PIO_ADDR_LSB +: PIO_ADDR_W],
                                  {ADDR_RSV_W{1'b0}}};
      addr_pin_oe_out         <= {parallel_io_lines_dir_in[`PIO_ADDR_LSB +: PIO_ADDR_W],
                                  {ADDR_RSV_W{1'b0}}};
      data_pin_out            <= {parallel_io_lines_data_in[`PIO_DATA_LSB +: PIO_DATA_W],
                                  {DATA_RSV_W{1'b0}}};
      data_pin_oe_out         <= {parallel_io_lines_dir_in[`PIO_DATA_LSB +: PIO_DATA_W],
                                  {DATA_RSV_W{1'b0}}};
      ctrl_pin_out            <= parallel_io_lines_data_in[`PIO_CTRL_LSB +: CTRL_W];
      ctrl_pin_oe_out         <= parallel_io_lines_dir_in[`PIO_CTRL_LSB +: CTRL_W];
      host_data_pins_out      <= parallel_io_lines_data_in[`PIO_HDATA_LSB +: HD_W];
      host_data_pins_oe_out   <= parallel_io_lines_dir_in[`PIO_HDATA_LSB +: HD_W];
      parallel_io_lines_out   <= {host_s2[HD_W+1], host_s2[HD_W], host_s2[HD_W-1:0], ctrl_s2,
                                  data_s2[DATA_W-1 -: PIO_DATA_W],
                                  addr_s2[ADDR_W-1 -: PIO_ADDR_W]};
      bus_error_out           <= disabled_access_in & peripheral_timeout_enable_in;
    end
  end

endmodule // parallel_host_pin_mux

/* src/strap_sync.v */
/*
  Two-stage synchroniser for the mode strap pin.
  Assumes one clock domain; it has no reset, so it tracks the strap
  through reset and the level is settled when reset lifts.
*/
`timescale 1ns/1ps

module strap_sync (
  input  wire clock_in,
  input  wire async_in,
  output wire sync_out
);

  reg stage_a;
  reg stage_b;

  always @(posedge clock_in) begin
    stage_a <= async_in;
    stage_b <= stage_a;
  end

  assign sync_out = stage_b;

endmodule // strap_sync

/* tb/pad_partner.sv */
/*
  Far side of the pads: memory devices and an external host.
  Assumes pad order {host data, control, data, address}, host controls on top.
*/
`timescale 1ns/1ps
module pad_partner (
  input  wire        clock_in,
  input  wire [75:0] pad_out,
  input  wire [75:0] pad_oe,
  output wire [77:0] pad_in
);
  logic [77:0] drive = 78'h0;
  logic        phase = 1'b0;
  // Host alternates address and data bytes on the same pins; free pads never hold
  always @(posedge clock_in) begin
    phase <= ~phase;
    drive <= {phase, ~phase, 76'({$urandom, $urandom, $urandom})};
  end
  assign pad_in = {drive[77:76], (pad_oe & pad_out) | (~pad_oe & drive[75:0])};
endmodule // pad_partner

/* tb/parallel_host_pin_mux_chk.sv */
/*
  Checker for the pin multiplexer, bound to its top-level ports.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module parallel_host_pin_mux_chk (
  input wire        clock_in, reset_n_in, mem_clock_enable_out, host_port_enable_out,
  input wire        mux_mode_strap_pin_in,
  input wire        bus_error_out, disabled_access_in, peripheral_timeout_enable_in,
  input wire [19:0] mem_addr_in, addr_pin_out, addr_pin_oe_out,
  input wire [31:0] data_pin_in, data_pin_oe_out, mem_data_out,
  input wire [15:0] ctrl_pin_out, ctrl_pin_oe_out, bus_selection_register_out,
  input wire [7:0]  host_data_pins_in, host_data_out,
  input wire [3:0]  mem_chip_enable_in, mem_byte_enable_in,
  input wire [45:0] parallel_io_lines_out, parallel_io_lines_dir_in
);
  wire m = bus_selection_register_out[0];
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  property p_fix; reset_n_in && $past(reset_n_in) && $past(reset_n_in, 2)
    |-> $stable(bus_selection_register_out); endproperty
  a_fix: assert property (p_fix) else $error("mode moved");
  property p_strap; $past(reset_n_in) && !$past(reset_n_in, 2)
    |-> m == $past(mux_mode_strap_pin_in, 3); endproperty
  a_strap: assert property (p_strap) else $error("strap capture");
  property p_bsr; bus_selection_register_out[15:1] == 15'h0; endproperty
  a_bsr: assert property (p_bsr) else $error("status bits");
  property p_gate; mem_clock_enable_out == m && host_port_enable_out == m; endproperty
  a_gate: assert property (p_gate) else $error("enables");
  property p_rsv; !m |-> addr_pin_oe_out[15:0] == 16'h0 && data_pin_oe_out[15:0] == 16'h0
    && addr_pin_out[15:0] == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved pins");
  property p_addr; m && $past(m) |-> addr_pin_out == $past(mem_addr_in); endproperty
  a_addr: assert property (p_addr) else $error("address route");
  property p_ctrl; m && $past(m) |-> ctrl_pin_out[7:4] == $past(mem_chip_enable_in)
    && ctrl_pin_out[11:8] == $past(mem_byte_enable_in) && !ctrl_pin_out[3]; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control route");
  property p_off; !m |-> mem_data_out == 32'h0 && host_data_out == 8'h0; endproperty
  a_off: assert property (p_off) else $error("controllers see pins");
  property p_pio; !m && $past(reset_n_in) && $past(reset_n_in, 2) && $past(reset_n_in, 3)
    |-> parallel_io_lines_out[19:4] == $past(data_pin_in[31:16], 3)
    && parallel_io_lines_out[43:36] == $past(host_data_pins_in, 3); endproperty
  a_pio: assert property (p_pio) else $error("io lines");
  property p_dir; !m && $past(reset_n_in)
    |-> ctrl_pin_oe_out == $past(parallel_io_lines_dir_in[35:20]); endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_err; !m && $past(reset_n_in) |-> bus_error_out ==
    ($past(disabled_access_in) & $past(peripheral_timeout_enable_in)); endproperty
  a_err: assert property (p_err) else $error("bus error");
endmodule // parallel_host_pin_mux_chk

bind parallel_host_pin_mux parallel_host_pin_mux_chk chk_inst (.clock_in, .reset_n_in,
  .mux_mode_strap_pin_in,
  .mem_clock_enable_out, .host_port_enable_out, .bus_error_out, .disabled_access_in,
  .peripheral_timeout_enable_in, .mem_addr_in, .addr_pin_out, .addr_pin_oe_out, .data_pin_in,
  .data_pin_oe_out, .mem_data_out, .ctrl_pin_out, .ctrl_pin_oe_out, .bus_selection_register_out,
  .host_data_pins_in, .host_data_out, .mem_chip_enable_in, .mem_byte_enable_in,
  .parallel_io_lines_out, .parallel_io_lines_dir_in);

/* tb/tb_parallel_host_pin_mux.sv */
/*
  Testbench for the pin multiplexer: random traffic in both strap modes.
  Assumes default widths and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb_parallel_host_pin_mux;
  logic         clock_in = 1'b0, reset_n_in = 1'b0, strap = 1'b0, m_exp = 1'b0;
  logic [170:0] d = 171'h0, q1 = 171'h0;
  logic [191:0] rnd;
  logic [77:0]  p1 = 78'h0, p2 = 78'h0, p3 = 78'h0;
  wire  [77:0]  pi;
  wire  [75:0]  po, pe;
  wire  [45:0]  lines;
  wire  [43:0]  back;
  wire  [16:0]  st;
  wire  [1:0]   en;
  int           cnt = 0, miscompares = 0, n_checks = 0;

  parallel_host_pin_mux parallel_host_pin_mux_inst (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .mux_mode_strap_pin_in(strap), .addr_pin_in(pi[19:0]),
    .addr_pin_out(po[19:0]), .addr_pin_oe_out(pe[19:0]), .data_pin_in(pi[51:20]),
    .data_pin_out(po[51:20]), .data_pin_oe_out(pe[51:20]), .ctrl_pin_in(pi[67:52]),
    .ctrl_pin_out(po[67:52]), .ctrl_pin_oe_out(pe[67:52]), .host_data_pins_in(pi[75:68]),
    .host_data_pins_out(po[75:68]), .host_data_pins_oe_out(pe[75:68]),
    .host_control_pin_0_in(pi[76]), .host_control_pin_1_in(pi[77]), .mem_addr_in(d[19:0]),
    .mem_data_in(d[51:20]), .mem_data_oe_in(d[52]), .mem_data_out(back[31:0]),
    .mem_read_strobe_in(d[53]), .mem_output_strobe_in(d[54]), .mem_write_strobe_in(d[55]),
    .memory_ready_input_out(back[32]), .mem_chip_enable_in(d[59:56]),
    .mem_byte_enable_in(d[63:60]), .sync_dram_clock_enable_in(d[64]),
    .sync_output_enable_three_in(d[65]), .mem_hold_request_in(d[66]),
    .mem_hold_request_out(back[33]), .hold_acknowledge_in(d[67]), .mem_clock_enable_out(en[1]),
    .host_data_in(d[75:68]), .host_data_oe_in(d[76]), .host_data_out(back[41:34]),
    .host_address_strobe_out(back[42]), .host_byte_identify_out(back[43]),
    .host_port_enable_out(en[0]), .parallel_io_lines_data_in(d[122:77]),
    .parallel_io_lines_dir_in(d[168:123]), .parallel_io_lines_out(lines),
    .peripheral_timeout_enable_in(d[169]), .disabled_access_in(d[170]),
    .bus_error_out(st[16]), .bus_selection_register_out(st[15:0]));
  pad_partner pad_partner_inst (.clock_in(clock_in), .pad_out(po), .pad_oe(pe), .pad_in(pi));

  function automatic logic [75:0] pmap(input logic m, input logic [170:0] q);
    pmap = m ? {q[75:68], q[67], 1'b0, q[65:56], 1'b0, q[55:53], q[51:0]}
             : {q[120:81], 16'h0, q[80:77], 16'h0};
  endfunction
  function automatic logic [45:0] lmap(input logic m, input logic [77:0] p);
    lmap = m ? 46'h0 : {p[77:36], p[19:16]};
  endfunction
  function automatic logic [43:0] bmap(input logic m, input logic [77:0] p);
    bmap = m ? {p[77:68], p[66], p[55], p[51:20]} : 44'h0;
  endfunction
  task automatic check(input logic [75:0] got, input logic [75:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial forever #12.5 clock_in = ~clock_in;
  // Stimulus with all-ones and all-zeros corner cycles; strap moved after release
  always @(posedge clock_in) begin
    rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    d <= (cnt == 10) ? ~171'h0 : (cnt == 11) ? 171'h0 : rnd[170:0];
    strap <= !reset_n_in ? m_exp : (cnt == 20) ? ~m_exp : strap;
    q1 <= d;
    p1 <= pi;
    p2 <= p1;
    p3 <= p2;
    cnt <= reset_n_in ? cnt + 1 : 0;
  end
  always @(negedge clock_in) begin
    if (cnt >= 5) begin
      check(po, pmap(m_exp, q1));
      check(lines, lmap(m_exp, p3));
      check(back, bmap(m_exp, p3));
      check(st, {!m_exp & q1[170] & q1[169], 15'h0, m_exp});
      check(en, {m_exp, m_exp});
      if (!m_exp) check(pe, pmap(1'b0, q1 >> 46));
      else check(pe, {{8{q1[76]}}, 16'hBFF7, {32{q1[52]}}, 20'hFFFFF});
    end
  end
  initial begin
    void'($urandom(71187));
    for (int r = 0; r < 4; r++) begin
      if (r > 0) begin
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        @(posedge clock_in);
      end
      m_exp = r[0] ^ r[1];
      repeat (4) @(posedge clock_in);
      reset_n_in <= 1'b1;
      repeat (60) @(posedge clock_in);
    end
    end_sim;
  end
  initial begin
    repeat (2000) @(posedge clock_in);
    miscompares++;
    end_sim;
  end
endmodule // tb_parallel_host_pin_mux
